// ### boost_prot_pkg.sv
// package: constants and types of the boost-stage protection block
package boost_prot_pkg;

   // clock and derived timing
   localparam int CLK_RATE_HZ      = 50_000_000;
   localparam int CLK_PERIOD_NS    = 20;
   localparam int SAMPLE_PERIOD_NS = 20_000;
   localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int INTEG_RATE_HZ    = 12_500;
   localparam int INTEG_CYCLES     = CLK_RATE_HZ / INTEG_RATE_HZ;
   localparam int WINDOW_1S_MS     = 1000;
   localparam int WINDOW_1S_SAMPLES =
      WINDOW_1S_MS * 1_000_000 / SAMPLE_PERIOD_NS;
   localparam int HALF_MS_US       = 500;
   localparam int HALF_MS_CYCLES   = HALF_MS_US * 1000 / CLK_PERIOD_NS;

   // clamp on-time threshold steps and offsets
   localparam int STEP_1S_US      = 5120;
   localparam int BASE_1S_US      = 2560;
   localparam int STEP_2S_US      = 10240;
   localparam int BASE_2S_US      = 5120;
   localparam int STEP_1S_SAMPLES = STEP_1S_US * 1000 / SAMPLE_PERIOD_NS;
   localparam int BASE_1S_SAMPLES = BASE_1S_US * 1000 / SAMPLE_PERIOD_NS;
   localparam int STEP_2S_SAMPLES = STEP_2S_US * 1000 / SAMPLE_PERIOD_NS;
   localparam int BASE_2S_SAMPLES = BASE_2S_US * 1000 / SAMPLE_PERIOD_NS;

   // overvoltage trip level in volts
   localparam logic [8:0] OV_BASE_120_V = 9'h0e3;
   localparam logic [8:0] OV_CAP_120_V  = 9'h0fe;
   localparam logic [8:0] OV_BASE_230_V = 9'h1b0;
   localparam logic [8:0] OV_CAP_230_V  = 9'h1fc;
   localparam logic [8:0] OV_STEP_V     = 9'h002;

   // leaky integrator
   localparam int         LEAK_SHIFT  = 6;
   localparam logic [9:0] INTEG_INPUT = 10'h008;

   // low-line delay codes in half milliseconds
   localparam logic [7:0][3:0] LL_HALFMS =
      {4'ha, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h2, 4'h0};

   // register offsets
   localparam logic [7:0] REG_CLAMP_CFG = 8'h54;
   localparam logic [7:0] REG_OV_CFG    = 8'h55;
   localparam logic [7:0] REG_LL_CFG    = 8'h56;
   localparam logic [7:0] REG_STATUS    = 8'h57;
   localparam logic [7:0] REG_MASK      = 8'h58;
   localparam logic [7:0] REG_STATE     = 8'h59;

   // status and mask bit positions
   localparam int EV_CLAMP = 0;
   localparam int EV_OV    = 1;
   localparam int EV_LL    = 2;
   localparam int EV_START = 3;

   // register layouts, msb first
   typedef struct packed {
      logic [6:0] thr;
      logic       sel;
   } clamp_cfg_t;

   typedef struct packed {
      logic [2:0] limit;
      logic [3:0] level;
      logic       policy;
   } ov_cfg_t;

   typedef struct packed {
      logic [2:0] delay;
      logic       retry;
   } ll_cfg_t;

   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   // analog sense levels from the boost stage
   typedef struct packed {
      logic clamp_on;
      logic ov_above;
      logic at_nominal;
      logic lowline;
   } sense_t;

endpackage

// ### boost_protect.sv
// boost-stage protection: clamp overpower, overvoltage, low-line, start
//
// Notes on behaviour
// - sample clamp every 20 us, compare window total
// - one-second threshold: field times 5.12 ms plus 2.56
// - two-second threshold: field times 10.24 ms plus 5.12
// - window select bit: 0 one second, 1 two
// - leaky integrator 63/64, 12.5 kHz, input eight
// - integrator limit zero trips at once, else filters
// - 120 V trip level 227 plus 2n, max 254
// - 230 V trip level 432 plus 2n, max 508
// - start policy: wait temperature check or only lock
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`default_nettype none

module boost_protect #(
   parameter bit HIGH_LINE       = 1'b0,
   parameter int WIN_1S_SAMPLES  = boost_prot_pkg::WINDOW_1S_SAMPLES,
   parameter int HALF_MS_CYCLES  = boost_prot_pkg::HALF_MS_CYCLES,
   parameter int SAMPLE_CYCLES   = boost_prot_pkg::SAMPLE_CYCLES
) (
   // clock, reset, enable
   input  wire logic                     clock_i,
   input  wire logic                     resetn_i,
   input  wire logic                     ce_i,
   // register port
   input  wire boost_prot_pkg::reg_req_t reg_req_i,
   output logic [7:0]                    rdata_o,
   // analog sense pins
   input  wire boost_prot_pkg::sense_t   sense_i,
   // power-up sequencing from the controller
   input  wire logic                     converter_locked_i,
   input  wire logic                     temp_check_done_i,
   input  wire logic                     temp_check_pass_i,
   // boost stage control
   output logic                          boost_enable_o,
   output logic                          clamp_overpower_o,
   output logic                          boost_overvoltage_o,
   output logic                          boost_lowline_o,
   output logic [8:0]                    overvoltage_trip_level_o,
   output logic                          upper_current_limit_enable_o,
   // interrupt
   output logic                          irq_o
);

   typedef struct packed {
      boost_prot_pkg::clamp_cfg_t ccfg;
      boost_prot_pkg::ov_cfg_t    ocfg;
      boost_prot_pkg::ll_cfg_t    lcfg;
      logic [3:0]                 status;
      logic [3:0]                 mask;
      logic [7:0]                 rdata;
      boost_prot_pkg::sense_t     sync1;
      boost_prot_pkg::sense_t     sync2;
      logic [9:0]                 samp;
      logic [16:0]                win;
      logic [16:0]                on;
      logic                       cfault;
      logic                       ofault;
      logic [8:0]                 level;
      logic [17:0]                ll_tick;
      logic [3:0]                 ll_half;
      logic                       lfault;
      logic                       started;
   } prot_state_t;

   localparam logic [9:0]  SAMP_LAST = 10'(SAMPLE_CYCLES - 1);
   // comparator must not read above a zero level while in reset
   localparam logic [8:0]  LEVEL_RESET =
      HIGH_LINE ? boost_prot_pkg::OV_BASE_230_V
                : boost_prot_pkg::OV_BASE_120_V;
   localparam logic [16:0] WIN1_LAST = 17'(WIN_1S_SAMPLES - 1);
   localparam logic [16:0] WIN2_LAST = 17'(2 * WIN_1S_SAMPLES - 1);
   localparam logic [17:0] HALF_LAST = 18'(HALF_MS_CYCLES - 1);

   prot_state_t s_reg;
   prot_state_t s_next;
   logic [3:0]  events;
   logic        ov_trip;
   logic        samp_tick;
   logic [16:0] win_last;
   logic        boost_on;

   // clamp on-time limit in 20 us samples
   function automatic logic [16:0] clamp_threshold(
      input boost_prot_pkg::clamp_cfg_t c);
      if (c.sel) begin
         return 17'(c.thr) * 17'(boost_prot_pkg::STEP_2S_SAMPLES)
              + 17'(boost_prot_pkg::BASE_2S_SAMPLES);
      end
      return 17'(c.thr) * 17'(boost_prot_pkg::STEP_1S_SAMPLES)
           + 17'(boost_prot_pkg::BASE_1S_SAMPLES);
   endfunction

   // overvoltage trip level in volts, capped per variant
   function automatic logic [8:0] trip_level(input logic [3:0] f,
                                             input logic       hl);
      logic [8:0] v;
      v = (hl ? boost_prot_pkg::OV_BASE_230_V
              : boost_prot_pkg::OV_BASE_120_V)
        + 9'(f) * boost_prot_pkg::OV_STEP_V;
      if (hl) begin
         return (v > boost_prot_pkg::OV_CAP_230_V) ?
                boost_prot_pkg::OV_CAP_230_V : v;
      end
      return (v > boost_prot_pkg::OV_CAP_120_V) ?
             boost_prot_pkg::OV_CAP_120_V : v;
   endfunction

   // filtered overvoltage fault from the synchronised comparator
   ov_integrator u_integ (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .ce_i     (ce_i),
      .above_i  (s_reg.sync2.ov_above),
      .limit_i  (s_reg.ocfg.limit),
      .trip_o   (ov_trip)
   );

   // boost runs only once started and while no fault is active
   assign boost_on  = s_reg.started & ~s_reg.ofault & ~s_reg.lfault
                    & ~s_reg.cfault;
   assign samp_tick = (s_reg.samp == SAMP_LAST);
   assign win_last  = s_reg.ccfg.sel ? WIN2_LAST : WIN1_LAST;

   // next-state logic; ce low freezes everything
   always_comb begin
      s_next = s_reg;
      events = 4'h0;
      if (ce_i) begin
         s_next.sync1 = sense_i;
         s_next.sync2 = s_reg.sync1;
         s_next.rdata = 8'h00;

         // register writes; status is write-one-to-clear
         if (reg_req_i.wr) begin
            case (reg_req_i.addr)
               boost_prot_pkg::REG_CLAMP_CFG:
                  s_next.ccfg = reg_req_i.wdata;
               boost_prot_pkg::REG_OV_CFG:
                  s_next.ocfg = reg_req_i.wdata;
               boost_prot_pkg::REG_LL_CFG:
                  s_next.lcfg = reg_req_i.wdata[7:4];
               boost_prot_pkg::REG_STATUS:
                  s_next.status = s_reg.status & ~reg_req_i.wdata[3:0];
               boost_prot_pkg::REG_MASK:
                  s_next.mask = reg_req_i.wdata[3:0];
               default: ;
            endcase
         end

         // register reads, data valid next cycle only
         if (reg_req_i.rd) begin
            case (reg_req_i.addr)
               boost_prot_pkg::REG_CLAMP_CFG: s_next.rdata = s_reg.ccfg;
               boost_prot_pkg::REG_OV_CFG:    s_next.rdata = s_reg.ocfg;
               boost_prot_pkg::REG_LL_CFG:
                  s_next.rdata = {s_reg.lcfg, 4'h0};
               boost_prot_pkg::REG_STATUS:
                  s_next.rdata = {4'h0, s_reg.status};
               boost_prot_pkg::REG_MASK:
                  s_next.rdata = {4'h0, s_reg.mask};
               boost_prot_pkg::REG_STATE:
                  s_next.rdata = {3'h0, boost_on, s_reg.started,
                                  s_reg.lfault, s_reg.ofault,
                                  s_reg.cfault};
               default: s_next.rdata = 8'h00;
            endcase
         end

         // clamp sampled once per 20 us
         s_next.samp = samp_tick ? 10'h000 : s_reg.samp + 10'h001;
         if (samp_tick) begin
            if (s_reg.win >= win_last) begin
               // window over: start a fresh accumulation
               s_next.win    = 17'h00000;
               s_next.on     = 17'h00000;
               s_next.cfault = 1'b0;
            end else begin
               s_next.win = s_reg.win + 17'h00001;
               s_next.on  = s_reg.on + 17'(s_reg.sync2.clamp_on);
               if (s_next.on > clamp_threshold(s_reg.ccfg)) begin
                  s_next.cfault = 1'b1;
               end
            end
         end

         // trip level for the analog comparator
         s_next.level = trip_level(s_reg.ocfg.level, HIGH_LINE);

         // latch or retry once back at nominal; trip wins
         if (ov_trip) begin
            s_next.ofault = 1'b1;
         end else if (s_reg.lcfg.retry && !s_reg.sync2.ov_above &&
                      s_reg.sync2.at_nominal) begin
            s_next.ofault = 1'b0;
         end

         if (!s_reg.sync2.lowline) begin
            s_next.ll_tick = 18'h00000;
            s_next.ll_half = 4'h0;
            s_next.lfault  = 1'b0;
         end else if (s_reg.ll_half >=
                      boost_prot_pkg::LL_HALFMS[s_reg.lcfg.delay]) begin
            s_next.lfault = 1'b1;
         end else if (s_reg.ll_tick == HALF_LAST) begin
            s_next.ll_tick = 18'h00000;
            s_next.ll_half = s_reg.ll_half + 4'h1;
         end else begin
            s_next.ll_tick = s_reg.ll_tick + 18'h00001;
         end

         if (!s_reg.started && converter_locked_i &&
             (s_reg.ocfg.policy ||
              (temp_check_done_i && temp_check_pass_i))) begin
            s_next.started = 1'b1;
         end

         // sticky events; a set in the clear cycle survives
         events[boost_prot_pkg::EV_CLAMP] = s_next.cfault & ~s_reg.cfault;
         events[boost_prot_pkg::EV_OV]    = s_next.ofault & ~s_reg.ofault;
         events[boost_prot_pkg::EV_LL]    = s_next.lfault & ~s_reg.lfault;
         events[boost_prot_pkg::EV_START] =
            s_next.started & ~s_reg.started;
         s_next.status = s_next.status | events;
      end
   end

   // state register, all clears on reset except the trip level
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_reg       <= '0;
         s_reg.level <= LEVEL_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from state
   assign rdata_o                  = s_reg.rdata;
   assign boost_enable_o           = boost_on;
   assign clamp_overpower_o        = s_reg.cfault;
   assign boost_overvoltage_o      = s_reg.ofault;
   assign boost_lowline_o          = s_reg.lfault;
   assign overvoltage_trip_level_o = s_reg.level;
   // retrying needs the upper current limit to drain the capacitor
   assign upper_current_limit_enable_o = s_reg.lcfg.retry & s_reg.ofault;
   assign irq_o                    = |(s_reg.status & s_reg.mask);

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   property p_sample_hold;
      (ce_i && !samp_tick) |=> $stable(s_reg.on);
   endproperty
   a_sample_hold: assert property (p_sample_hold)
      else $error("clamp total moved between samples");

   property p_thr_1s;
      (!s_reg.ccfg.sel && $rose(s_reg.cfault) && $stable(s_reg.ccfg)) |->
         s_reg.on == 17'(s_reg.ccfg.thr) * 17'h00100 + 17'h00081;
   endproperty
   a_thr_1s: assert property (p_thr_1s)
      else $error("one-second clamp threshold wrong");

   property p_thr_2s;
      (s_reg.ccfg.sel && $rose(s_reg.cfault) && $stable(s_reg.ccfg)) |->
         s_reg.on == 17'(s_reg.ccfg.thr) * 17'h00200 + 17'h00101;
   endproperty
   a_thr_2s: assert property (p_thr_2s)
      else $error("two-second clamp threshold wrong");

   property p_window_end;
      (ce_i && samp_tick && s_reg.win == win_last) |=>
         (s_reg.win == 17'h00000 && s_reg.on == 17'h00000 && !s_reg.cfault);
   endproperty
   a_window_end: assert property (p_window_end)
      else $error("clamp window did not restart");

   property p_level_120;
      (!HIGH_LINE && $past(ce_i)) |->
         (s_reg.level <= 9'h0fe && s_reg.level >= 9'h0e3);
   endproperty
   a_level_120: assert property (p_level_120)
      else $error("120 V trip level out of range");

   property p_level_230;
      (HIGH_LINE && $past(ce_i)) |->
         (s_reg.level <= 9'h1fc && s_reg.level >= 9'h1b0);
   endproperty
   a_level_230: assert property (p_level_230)
      else $error("230 V trip level out of range");

   property p_start_policy;
      $rose(s_reg.started) |-> $past(converter_locked_i &&
         (s_reg.ocfg.policy || (temp_check_done_i && temp_check_pass_i)));
   endproperty
   a_start_policy: assert property (p_start_policy)
      else $error("boost started against policy");

   property p_ov_latch;
      (!s_reg.lcfg.retry && s_reg.ofault) |=> s_reg.ofault;
   endproperty
   a_ov_latch: assert property (p_ov_latch)
      else $error("latched overvoltage fault cleared");

   property p_lowline_delay;
      $rose(s_reg.lfault) |->
         $past(s_reg.ll_half) >=
            boost_prot_pkg::LL_HALFMS[$past(s_reg.lcfg.delay)]
         && $past(s_reg.sync2.lowline);
   endproperty
   a_lowline_delay: assert property (p_lowline_delay)
      else $error("low-line fault too early");

   c_clamp_fault: cover property ($rose(s_reg.cfault));
   c_ov_retry:    cover property (s_reg.lcfg.retry && $fell(s_reg.ofault));
   c_irq:         cover property ($rose(irq_o));

endmodule

`default_nettype wire

// ### boost_stage_model.sv
// behavioural boost stage: output voltage, clamp and line comparators
`timescale 1ns/10ps
`default_nettype none

module boost_stage_model #(
   parameter int NOMINAL_V = 200
) (
   // stage state set by the bench
   input  wire logic                   clamp_i,
   input  wire logic [9:0]             volts_i,
   input  wire logic                   lowline_i,
   // trip level chosen by the block
   input  wire logic [8:0]             trip_level_i,
   // comparator levels back to the block
   output var  boost_prot_pkg::sense_t sense_o
);
   // raw comparators, no hysteresis; the block synchronises them
   always_comb begin
      sense_o.clamp_on   = clamp_i;
      sense_o.ov_above   = volts_i > {1'b0, trip_level_i};
      sense_o.at_nominal = volts_i <= 10'(NOMINAL_V);
      sense_o.lowline    = lowline_i;
   end
endmodule

`default_nettype wire

// ### ov_integrator.sv
// leaky integrator that filters the boost overvoltage comparator
`timescale 1ns/10ps
`default_nettype none

module ov_integrator (
   // clock, reset, enable
   input  wire logic       clock_i,
   input  wire logic       resetn_i,
   input  wire logic       ce_i,
   // comparator level and filter limit
   input  wire logic       above_i,
   input  wire logic [2:0] limit_i,
   // filtered fault
   output logic            trip_o
);

   typedef struct packed {
      logic [11:0] tick;
      logic [9:0]  acc;
      logic        trip;
   } integ_state_t;

   localparam logic [11:0] TICK_LAST =
      12'(boost_prot_pkg::INTEG_CYCLES - 1);

   integ_state_t s_reg;
   integ_state_t s_next;

   // integrator step at 12.5 kHz, leak 1/64 each step
   always_comb begin
      s_next = s_reg;
      if (ce_i) begin
         if (s_reg.tick == TICK_LAST) begin
            s_next.tick = 12'h000;
            s_next.acc = s_reg.acc
               - (s_reg.acc >> boost_prot_pkg::LEAK_SHIFT)
               + (above_i ? boost_prot_pkg::INTEG_INPUT : 10'h000);
         end else begin
            s_next.tick = s_reg.tick + 12'h001;
         end
         s_next.trip = (limit_i == 3'h0) ? above_i :
                       (s_next.acc > {1'b0, limit_i, 6'h00});
      end
   end

   // state register
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign trip_o = s_reg.trip;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   property p_integ_step;
      (ce_i && s_reg.tick == TICK_LAST && above_i) |=>
         s_reg.acc == $past(s_reg.acc) - ($past(s_reg.acc) >> 6) + 10'h008;
   endproperty
   a_integ_step: assert property (p_integ_step)
      else $error("integrator step wrong");

   property p_no_filter;
      (ce_i && limit_i == 3'h0) |=> trip_o == $past(above_i);
   endproperty
   a_no_filter: assert property (p_no_filter)
      else $error("unfiltered trip does not follow comparator");

   c_filtered_trip: cover property (limit_i != 3'h0 && $rose(trip_o));

endmodule

`default_nettype wire

// ### tb_boost_stage_protection.sv
// self-checking bench for the boost-stage protection block
`timescale 1ns/10ps
`default_nettype none

module tb_boost_stage_protection;
   logic                     clock_i, resetn_i, locked, tdone, tpass;
   logic                     clamp, lowline, boost_en, clamp_f, ov_f;
   logic                     ll_f, ucl, irq;
   logic [9:0]               volts;
   logic [7:0]               rdata;
   logic [8:0]               trip_level, trip_hl;
   boost_prot_pkg::reg_req_t req;
   boost_prot_pkg::sense_t   sense;
   int                       n_fail, checks;

   // short sample, window and half-ms counts keep the run brief
   boost_protect #(.HIGH_LINE(1'b0), .WIN_1S_SAMPLES(200),
                   .HALF_MS_CYCLES(10), .SAMPLE_CYCLES(10)) dut (
      .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(1'b1),
      .reg_req_i(req), .rdata_o(rdata), .sense_i(sense),
      .converter_locked_i(locked), .temp_check_done_i(tdone),
      .temp_check_pass_i(tpass), .boost_enable_o(boost_en),
      .clamp_overpower_o(clamp_f), .boost_overvoltage_o(ov_f),
      .boost_lowline_o(ll_f), .overvoltage_trip_level_o(trip_level),
      .upper_current_limit_enable_o(ucl), .irq_o(irq));

   // second instance covers the 230 V variant trip level
   boost_protect #(.HIGH_LINE(1'b1)) dut_hl (
      .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(1'b1),
      .reg_req_i(req), .rdata_o(), .sense_i(sense),
      .converter_locked_i(locked), .temp_check_done_i(tdone),
      .temp_check_pass_i(tpass), .boost_enable_o(),
      .clamp_overpower_o(), .boost_overvoltage_o(),
      .boost_lowline_o(), .overvoltage_trip_level_o(trip_hl),
      .upper_current_limit_enable_o(), .irq_o());

   boost_stage_model #(.NOMINAL_V(200)) stage (
      .clamp_i(clamp), .volts_i(volts), .lowline_i(lowline),
      .trip_level_i(trip_level), .sense_o(sense));

   // 50 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end

   task automatic check(input logic [8:0] got, exp,
                        input string what = "value");
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic hold(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   // bus cycles: one-cycle strobes, read data the cycle after
   task automatic wr(input logic [7:0] a, d);
      @(posedge clock_i);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock_i);
      req.wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, exp);
      @(posedge clock_i);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock_i);
      req.rd <= 1'b0;
      #1 check({1'b0, rdata}, {1'b0, exp}, "read data");
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: pick = boost_en;
         1: pick = ov_f;
         2: pick = ll_f;
         3: pick = clamp_f;
         default: pick = irq;
      endcase
   endfunction

   // bounded wait; running out ends the run
   task automatic wait_for(input int s, input logic val, input int lim);
      int i;
      i = 0;
      while (pick(s) !== val && i < lim) begin
         @(posedge clock_i);
         #1 i++;
      end
      checks++;
      if (i >= lim) begin
         n_fail++;
         $display("[FAIL] %0t wait on output %0d timed out", $time, s);
         results();
      end
   endtask

   task automatic do_reset;
      @(posedge clock_i);
      resetn_i <= 1'b0;
      repeat (8) @(posedge clock_i);
      resetn_i <= 1'b1;
      hold(2);
   endtask

   task automatic t_regs;
      for (int a = 8'h54; a <= 8'h5a; a++)
         rd_chk(8'(a), 8'h00);
      check(trip_level, 9'h0e3);
      wr(8'h54, 8'ha5);
      rd_chk(8'h54, 8'ha5);
      wr(8'h56, 8'hff);
      rd_chk(8'h56, 8'hf0);
      wr(8'h59, 8'hff);
      rd_chk(8'h59, 8'h00);
      wr(8'h5a, 8'hff);
      rd_chk(8'h5a, 8'h00);
      wr(8'h54, 8'h00);
      wr(8'h56, 8'h00);
      $display("test regs done");
   endtask

   task automatic t_trip;
      for (int n = 0; n < 16; n++) begin
         wr(8'h55, {3'h0, 4'(n), 1'b0});
         hold(2);
         check(trip_level,
               (227 + 2 * n > 254) ? 9'h0fe : 9'(227 + 2 * n));
         check(trip_hl, 9'(432 + 2 * n));
      end
      $display("test trip level done");
   endtask

   task automatic t_start;
      wr(8'h58, 8'h0f);
      wr(8'h55, 8'h00);
      locked <= 1'b1;
      tdone <= 1'b1;
      hold(20);
      check(boost_en, 1'b0);
      tpass <= 1'b1;
      wait_for(0, 1'b1, 10);
      check(irq, 1'b1);
      rd_chk(8'h57, 8'h08);
      wr(8'h57, 8'h08);
      rd_chk(8'h57, 8'h00);
      check(irq, 1'b0);
      tdone <= 1'b0;
      tpass <= 1'b0;
      do_reset();
      wr(8'h55, 8'h01);
      wait_for(0, 1'b1, 10);
      $display("test start policy done");
   endtask

   task automatic t_ov;
      wr(8'h58, 8'h0f);
      volts <= 10'd230;
      wait_for(1, 1'b1, 10);
      check(boost_en, 1'b0);
      check(ucl, 1'b0);
      volts <= 10'd100;
      hold(20);
      check(ov_f, 1'b1);
      rd_chk(8'h57, 8'h0a);
      wr(8'h57, 8'h0f);
      rd_chk(8'h57, 8'h00);
      check(irq, 1'b0);
      do_reset();
      wr(8'h55, 8'h01);
      wr(8'h56, 8'h10);
      wait_for(0, 1'b1, 10);
      volts <= 10'd230;
      wait_for(1, 1'b1, 10);
      check(ucl, 1'b1);
      volts <= 10'd150;
      wait_for(1, 1'b0, 20);
      check(ucl, 1'b0);
      wait_for(0, 1'b1, 10);
      $display("test overvoltage done");
   endtask

   task automatic t_lowline;
      wr(8'h56, 8'h40);
      lowline <= 1'b1;
      hold(30);
      check(ll_f, 1'b0);
      wait_for(2, 1'b1, 25);
      check(boost_en, 1'b0);
      lowline <= 1'b0;
      wait_for(2, 1'b0, 5);
      wr(8'h56, 8'h00);
      lowline <= 1'b1;
      wait_for(2, 1'b1, 5);
      lowline <= 1'b0;
      wait_for(2, 1'b0, 5);
      $display("test lowline done");
   endtask

   // clamp on-time against both windows, window phase from reset
   task automatic t_clamp;
      do_reset();
      clamp <= 1'b1;
      hold(1200);
      check(clamp_f, 1'b0);
      wait_for(3, 1'b1, 200);
      hold(650);
      check(clamp_f, 1'b1);
      wait_for(3, 1'b0, 100);
      wr(8'h54, 8'h01);
      hold(1900);
      check(clamp_f, 1'b0);
      wait_for(3, 1'b1, 800);
      clamp <= 1'b0;
      hold(1400);
      check(clamp_f, 1'b1);
      wait_for(3, 1'b0, 60);
      $display("test clamp done");
   endtask

   // filtered trip: a short crossing alone must not trip
   task automatic t_integ;
      do_reset();
      volts <= 10'd100;
      wr(8'h55, 8'h21);
      volts <= 10'd230;
      hold(100);
      volts <= 10'd100;
      hold(4000);
      check(ov_f, 1'b0);
      volts <= 10'd230;
      hold(27000);
      check(ov_f, 1'b0);
      wait_for(1, 1'b1, 12000);
      $display("test integrator done");
   endtask

   initial begin
      resetn_i = 1'b0;
      req = '0;
      locked = 1'b0;
      tdone = 1'b0;
      tpass = 1'b0;
      clamp = 1'b0;
      lowline = 1'b0;
      volts = 10'd100;
      n_fail = 0;
      checks = 0;
      do_reset();
      t_regs();
      t_trip();
      t_start();
      t_ov();
      t_lowline();
      t_clamp();
      t_integ();
      results();
   end
endmodule

`default_nettype wire
